// ### core/cpxfer_pkg.sv
// Purpose: Shared constants for the coprocessor data transfer link.
// Assumes: One clock domain, pclk at 20 MHz.
// Notes: Instruction field positions, register map and reset values.
package cpxfer_pkg;
    // ==========================================================
    // Instruction fields
    localparam int OFFSET_LSB = 0;
    localparam int OFFSET_W = 8;
    localparam int OFFSET_SHIFT = 2;
    localparam int CPNUM_LSB = 8;
    localparam int FIELD4_W = 4;
    localparam int DEST_LSB = 12;
    localparam int BASE_LSB = 16;
    localparam int LOAD_BIT = 20;
    localparam int WB_BIT = 21;
    localparam int LEN_BIT = 22;
    localparam int UP_BIT = 23;
    localparam int PRE_BIT = 24;
    localparam logic [3:0] PC_REG_NUM = 4'h0f;
    localparam logic [31:0] PC_AHEAD = 32'h0000_0008;
    localparam logic [31:0] PC_MASK = 32'h03ff_fffc;
    localparam int ADDR_W = 26;
    localparam logic [ADDR_W-1:0] WORD_STEP = 26'h000_0004;
    localparam int LONG_WORDS = 16;
    localparam int SELECT_TIMEOUT = 8;
    // ==========================================================
    // Register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] INSTR_OFS = 8'h04;
    localparam logic [7:0] BASE_IN_OFS = 8'h08;
    localparam logic [7:0] PC_IN_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] BASE_OUT_OFS = 8'h14;
    localparam logic [7:0] ADDR_OFS = 8'h18;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h1c;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CACHE_BIT = 1;
    localparam int CTRL_PRIV_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WB_BIT = 1;
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ADDR_EXC_BIT = 1;
    localparam int IRQ_ABORT_BIT = 2;
    localparam int IRQ_NOCP_BIT = 3;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

// ### core/cpxfer_if.sv
// Purpose: Link between the processor transfer end and the coprocessor/memory end.
// Assumes: Both ends run on pclk.
// Notes: The shared data bus is resolved here from the two output enables.
interface cpxfer_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic cp_sel;
    logic [31:0] instr;
    logic cp_accept;
    logic mem_req;
    logic mem_write;
    logic [25:0] addr;
    logic user_translate_n;
    logic cache_en;
    logic mem_ack;
    logic mem_abort;
    logic last_word;
    logic data_bus_enable_in;
    logic [31:0] cp_store_data;
    logic [31:0] dev_bus_d;
    logic dev_bus_oe;
    logic [31:0] far_bus_d;
    logic far_bus_oe;
    wire [31:0] data_bus;

    // ==========================================================
    // Bus resolution
    assign data_bus = dev_bus_oe ? dev_bus_d : (far_bus_oe ? far_bus_d : 32'h0000_0000);

    modport dev (
        input pclk, presetn, cp_accept, mem_ack, mem_abort, last_word,
        input data_bus_enable_in, cp_store_data, data_bus,
        output cp_sel, instr, mem_req, mem_write, addr, user_translate_n, cache_en,
        output dev_bus_d, dev_bus_oe
    );
    modport far (
        input pclk, presetn, cp_sel, instr, mem_req, mem_write, addr,
        input user_translate_n, cache_en, dev_bus_oe, data_bus,
        output cp_accept, mem_ack, mem_abort, last_word, data_bus_enable_in,
        output cp_store_data, far_bus_d, far_bus_oe
    );
endinterface

// ### core/cpxfer_far.sv
// Purpose: Attached coprocessor with its memory system and memory manager.
// Assumes: One access answered one cycle after each request.
// Notes: A forced abort stops the transfer without side effects.
module cpxfer_far #(
    parameter logic [3:0] OWN_NUMBER = 4'h1
) (
    // Link
    cpxfer_if.far lnk,
    // User side
    input wire logic abort_force,
    input wire logic bus_enable,
    output logic [31:0] last_data,
    output logic [4:0] words_done
);
    logic [31:0] cp_regs [16];
    logic [31:0] mem [64];
    logic active_reg;
    logic load_reg;
    logic [3:0] idx_reg;
    logic [4:0] left_reg;
    logic [4:0] len_next;

    assign lnk.data_bus_enable_in = bus_enable;
    assign lnk.cp_store_data = cp_regs[idx_reg];
    assign len_next = lnk.instr[cpxfer_pkg::LEN_BIT] ? 5'(cpxfer_pkg::LONG_WORDS) : 5'h01;

    // ==========================================================
    // Selection, sequencing and memory
    always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
        if (!lnk.presetn) begin
            active_reg <= 1'b0;
            load_reg <= 1'b0;
            idx_reg <= 4'h0;
            left_reg <= 5'h00;
            lnk.cp_accept <= 1'b0;
            lnk.mem_ack <= 1'b0;
            lnk.mem_abort <= 1'b0;
            lnk.last_word <= 1'b0;
            lnk.far_bus_oe <= 1'b0;
            lnk.far_bus_d <= 32'h0000_0000;
            last_data <= 32'h0000_0000;
            words_done <= 5'h00;
        end else begin
            lnk.cp_accept <= 1'b0;
            lnk.mem_ack <= 1'b0;
            lnk.mem_abort <= 1'b0;
            lnk.last_word <= 1'b0;
            lnk.far_bus_oe <= 1'b0;
            if (lnk.cp_sel && !active_reg && !lnk.cp_accept &&
                lnk.instr[cpxfer_pkg::CPNUM_LSB +: cpxfer_pkg::FIELD4_W] == OWN_NUMBER) begin
                active_reg <= 1'b1;
                lnk.cp_accept <= 1'b1;
                load_reg <= lnk.instr[cpxfer_pkg::LOAD_BIT];
                idx_reg <= lnk.instr[cpxfer_pkg::DEST_LSB +: cpxfer_pkg::FIELD4_W];
                left_reg <= len_next;
                words_done <= 5'h00;
            end
            if (active_reg && lnk.mem_req) begin
                lnk.mem_ack <= 1'b1;
                lnk.mem_abort <= abort_force;
                lnk.last_word <= (left_reg == 5'h01);
                if (abort_force) begin
                    active_reg <= 1'b0;
                end else if (lnk.mem_write) begin
                    mem[lnk.addr[7:2]] <= lnk.data_bus;
                    last_data <= lnk.data_bus;
                end else begin
                    lnk.far_bus_oe <= 1'b1;
                    lnk.far_bus_d <= mem[lnk.addr[7:2]];
                end
            end
            if (active_reg && lnk.mem_ack && !lnk.mem_abort) begin
                if (load_reg) begin
                    cp_regs[idx_reg] <= lnk.data_bus;
                    last_data <= lnk.data_bus;
                end
                idx_reg <= idx_reg + 4'h1;
                left_reg <= left_reg - 5'h01;
                words_done <= words_done + 5'h01;
                if (left_reg == 5'h01) begin
                    active_reg <= 1'b0;
                end
            end
        end
    end
endmodule

// ### core/cpxfer_dev.sv
// Purpose: Processor end of coprocessor load/store transfers with APB control.
// Assumes: Base register and PC values are supplied by software via registers.
// Notes: Each word takes three cycles: a request cycle, a wait cycle and an answer cycle.
// Operation
// - Coprocessor answers only its own number
// - Bit 22 picks short or long transfer
// - Destination field names first register moved
// - Eight-bit offset shifted left two bits
// - Up bit adds offset, else subtracts
// - Pre bit applies offset before use
// - Pre-indexed writes base back when W set
// - Post-indexed always writes base back
// - First word at base, then plus four
// - PC base: no flags, eight ahead
// - Privileged post-indexed W drives translate pin low
// - Trap only on first address; later wrap
// - Check only the address actually used
// - Abort: trap, still write base back
// - Coprocessor survives or detects abort
// - Cache read on loads, updated on stores
// - Cache off store drives bus in latent cycle
// - Others keep bus off in latent cycle
module cpxfer_dev (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Link
    cpxfer_if.dev lnk
);
    typedef enum logic [2:0] {IDLE, SELECT, LATENT, XFER, WAIT} xfer_state_e;

    xfer_state_e state_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] instr_reg;
    logic [31:0] base_in_reg;
    logic [31:0] pc_in_reg;
    logic [31:0] base_out_reg;
    logic wb_valid_reg;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] irq_set;
    logic [3:0] tmo_reg;
    logic [31:0] mod_base_reg;
    logic write_back_reg;
    logic start;
    logic setup_ok;
    logic access;
    logic [31:0] base_eff;
    logic [31:0] offset;
    logic [31:0] mod_base;
    logic [31:0] first_addr;
    logic is_store;

    assign access = psel && penable;
    assign start = access && pwrite && paddr == cpxfer_pkg::CTRL_OFS &&
        pwdata[cpxfer_pkg::CTRL_START_BIT] && state_reg == IDLE;
    assign setup_ok = 1'b1;
    assign is_store = !instr_reg[cpxfer_pkg::LOAD_BIT];

    // ==========================================================
    // Address generation
    always_comb begin
        if (instr_reg[cpxfer_pkg::BASE_LSB +: cpxfer_pkg::FIELD4_W] ==
            cpxfer_pkg::PC_REG_NUM) begin
            base_eff = (pc_in_reg & cpxfer_pkg::PC_MASK) + cpxfer_pkg::PC_AHEAD;
        end else begin
            base_eff = base_in_reg;
        end
        offset = {22'h00_0000, instr_reg[cpxfer_pkg::OFFSET_LSB +: cpxfer_pkg::OFFSET_W],
            2'b00};
        if (instr_reg[cpxfer_pkg::UP_BIT]) begin
            mod_base = base_eff + offset;
        end else begin
            mod_base = base_eff - offset;
        end
        first_addr = instr_reg[cpxfer_pkg::PRE_BIT] ? mod_base : base_eff;
    end

    // ==========================================================
    // Transfer sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IDLE;
            tmo_reg <= 4'h0;
            mod_base_reg <= cpxfer_pkg::REG_RESET;
            write_back_reg <= 1'b0;
            base_out_reg <= cpxfer_pkg::REG_RESET;
            wb_valid_reg <= 1'b0;
            irq_set <= 4'h0;
            lnk.cp_sel <= 1'b0;
            lnk.instr <= cpxfer_pkg::REG_RESET;
            lnk.mem_req <= 1'b0;
            lnk.mem_write <= 1'b0;
            lnk.addr <= 26'h000_0000;
            lnk.user_translate_n <= 1'b1;
            lnk.cache_en <= 1'b0;
            lnk.dev_bus_oe <= 1'b0;
            lnk.dev_bus_d <= cpxfer_pkg::REG_RESET;
        end else begin
            irq_set <= 4'h0;
            lnk.mem_req <= 1'b0;
            lnk.dev_bus_oe <= 1'b0;
            lnk.user_translate_n <= 1'b1;
            case (state_reg)
                IDLE: begin
                    if (start) begin
                        wb_valid_reg <= 1'b0;
                        mod_base_reg <= mod_base;
                        write_back_reg <= !instr_reg[cpxfer_pkg::PRE_BIT] ||
                            instr_reg[cpxfer_pkg::WB_BIT];
                        lnk.addr <= first_addr[cpxfer_pkg::ADDR_W-1:0];
                        lnk.instr <= instr_reg;
                        lnk.mem_write <= is_store;
                        lnk.cache_en <= pwdata[cpxfer_pkg::CTRL_CACHE_BIT];
                        if (first_addr[31:cpxfer_pkg::ADDR_W] != 6'h00) begin
                            irq_set[cpxfer_pkg::IRQ_ADDR_EXC_BIT] <= 1'b1;
                        end else begin
                            lnk.cp_sel <= 1'b1;
                            tmo_reg <= 4'h0;
                            state_reg <= SELECT;
                        end
                    end
                end
                SELECT: begin
                    if (lnk.cp_accept) begin
                        lnk.cp_sel <= 1'b0;
                        state_reg <= LATENT;
                        lnk.dev_bus_d <= lnk.cp_store_data;
                        lnk.dev_bus_oe <= is_store && !lnk.cache_en &&
                            lnk.data_bus_enable_in;
                    end else if (tmo_reg == 4'(cpxfer_pkg::SELECT_TIMEOUT - 1)) begin
                        lnk.cp_sel <= 1'b0;
                        irq_set[cpxfer_pkg::IRQ_NOCP_BIT] <= 1'b1;
                        state_reg <= IDLE;
                    end else begin
                        tmo_reg <= tmo_reg + 4'h1;
                    end
                end
                LATENT: begin
                    lnk.mem_req <= 1'b1;
                    lnk.dev_bus_d <= lnk.cp_store_data;
                    lnk.dev_bus_oe <= is_store && lnk.data_bus_enable_in;
                    lnk.user_translate_n <= !(ctrl_reg[cpxfer_pkg::CTRL_PRIV_BIT] &&
                        !instr_reg[cpxfer_pkg::PRE_BIT] && instr_reg[cpxfer_pkg::WB_BIT]);
                    state_reg <= XFER;
                end
                XFER: begin
                    state_reg <= WAIT;
                end
                WAIT: begin
                    if (lnk.mem_ack) begin
                        if (lnk.mem_abort || lnk.last_word) begin
                            if (write_back_reg) begin
                                base_out_reg <= mod_base_reg;
                                wb_valid_reg <= 1'b1;
                            end
                            if (lnk.mem_abort) begin
                                irq_set[cpxfer_pkg::IRQ_ABORT_BIT] <= 1'b1;
                            end else begin
                                irq_set[cpxfer_pkg::IRQ_DONE_BIT] <= 1'b1;
                            end
                            state_reg <= IDLE;
                        end else begin
                            lnk.addr <= lnk.addr + cpxfer_pkg::WORD_STEP;
                            state_reg <= LATENT;
                        end
                    end
                end
                default: begin
                    state_reg <= IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= cpxfer_pkg::REG_RESET;
            instr_reg <= cpxfer_pkg::REG_RESET;
            base_in_reg <= cpxfer_pkg::REG_RESET;
            pc_in_reg <= cpxfer_pkg::REG_RESET;
            irq_mask_reg <= 4'h0;
        end else if (access && pwrite) begin
            if (paddr == cpxfer_pkg::CTRL_OFS) begin
                ctrl_reg <= {pwdata[31:1], 1'b0};
            end else if (paddr == cpxfer_pkg::INSTR_OFS && state_reg == IDLE) begin
                instr_reg <= pwdata;
            end else if (paddr == cpxfer_pkg::BASE_IN_OFS && state_reg == IDLE) begin
                base_in_reg <= pwdata;
            end else if (paddr == cpxfer_pkg::PC_IN_OFS && state_reg == IDLE) begin
                pc_in_reg <= pwdata;
            end else if (paddr == cpxfer_pkg::IRQ_MASK_OFS) begin
                irq_mask_reg <= pwdata[cpxfer_pkg::IRQ_W-1:0];
            end
        end
    end

    // ==========================================================
    // Interrupt status, cleared by reading; a new event wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 4'h0;
        end else if (access && !pwrite && paddr == cpxfer_pkg::IRQ_STAT_OFS) begin
            irq_stat_reg <= irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_stat_reg | irq_set) & irq_mask_reg);
        end
    end

    // ==========================================================
    // Read data and answer, given in the setup cycle for a zero-wait access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= cpxfer_pkg::REG_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable && setup_ok;
            pslverr <= 1'b0;
            prdata <= cpxfer_pkg::REG_RESET;
            if (psel && !penable) begin
                if (paddr == cpxfer_pkg::CTRL_OFS) begin
                    prdata <= ctrl_reg;
                end else if (paddr == cpxfer_pkg::INSTR_OFS) begin
                    prdata <= instr_reg;
                end else if (paddr == cpxfer_pkg::BASE_IN_OFS) begin
                    prdata <= base_in_reg;
                end else if (paddr == cpxfer_pkg::PC_IN_OFS) begin
                    prdata <= pc_in_reg;
                end else if (paddr == cpxfer_pkg::STATUS_OFS) begin
                    prdata <= {30'h0000_0000, wb_valid_reg, state_reg != IDLE};
                end else if (paddr == cpxfer_pkg::BASE_OUT_OFS) begin
                    prdata <= base_out_reg;
                end else if (paddr == cpxfer_pkg::ADDR_OFS) begin
                    prdata <= {6'h00, lnk.addr};
                end else if (paddr == cpxfer_pkg::IRQ_STAT_OFS) begin
                    prdata <= {28'h000_0000, irq_stat_reg};
                end else if (paddr == cpxfer_pkg::IRQ_MASK_OFS) begin
                    prdata <= {28'h000_0000, irq_mask_reg};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end
endmodule

// ### verification/cpxfer_assertions.sv
// Purpose: Concurrent checks on the link between the two transfer ends.
// Assumes: Both ends run on pclk; presetn is asynchronous, active low.
// Notes: Sees only the interface signals, instantiated beside the interface.
module cpxfer_assertions #(
    parameter logic [3:0] OWN_NUMBER = 4'h1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic cp_sel,
    input wire logic [31:0] instr,
    input wire logic cp_accept,
    input wire logic mem_req,
    input wire logic [25:0] addr,
    input wire logic user_translate_n,
    input wire logic cache_en,
    input wire logic mem_ack,
    input wire logic mem_abort,
    input wire logic last_word,
    input wire logic data_bus_enable_in,
    input wire logic dev_bus_oe,
    input wire logic far_bus_oe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Link checks
    a_accept_own_number: assert property (cp_accept |->
        $past(cp_sel) && $past(instr[11:8]) == OWN_NUMBER)
        else $error("accept without a matching select");
    a_answer_after_req: assert property (mem_req |=> mem_ack)
        else $error("memory access not answered next cycle");
    a_translate_low_cause: assert property (!user_translate_n |->
        mem_req && !instr[24] && instr[21])
        else $error("translate pin low outside a post-indexed write-back access");
    a_latent_bus_drive: assert property (cp_accept && !instr[20] && !cache_en &&
        data_bus_enable_in |=> dev_bus_oe)
        else $error("store data not driven in the latent cycle");
    a_bus_one_driver: assert property (!(dev_bus_oe && far_bus_oe))
        else $error("both ends drive the data bus");
    a_word_step: assert property (mem_req ##1 (mem_ack && !mem_abort && !last_word) |->
        ##2 (mem_req && addr == $past(addr, 3) + cpxfer_pkg::WORD_STEP))
        else $error("next word address is not one word higher");
    a_stop_at_last: assert property (last_word |=> !mem_req [*4])
        else $error("access requested after the last word");
    a_stop_at_abort: assert property (mem_abort |=> !mem_req [*4])
        else $error("access requested after an abort");
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench driving the processor end through APB and the coprocessor end directly.
// Assumes: pclk period 50 ns; presetn held low for 4 cycles.
// Notes: A monitor records the first and last address, the request count and the translate pin of each transfer.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic abort_force = 1'b0;
    logic bus_enable = 1'b1;
    logic [31:0] last_data;
    logic [4:0] words_done;
    logic [31:0] first_addr;
    logic [31:0] last_addr;
    logic [31:0] rd;
    logic user_translate_n_low;
    logic err;
    int nreq;
    int miscompares = 0;
    int checks = 0;
    cpxfer_if lnk_if (.pclk(pclk), .presetn(presetn));
    cpxfer_dev cpxfer_dev_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .lnk(lnk_if.dev));
    cpxfer_far #(.OWN_NUMBER(4'h1)) cpxfer_far_inst (.lnk(lnk_if.far), .abort_force(abort_force),
        .bus_enable(bus_enable), .last_data(last_data), .words_done(words_done));
    cpxfer_assertions #(.OWN_NUMBER(4'h1)) cpxfer_assertions_inst (.pclk(pclk), .presetn(presetn),
        .cp_sel(lnk_if.cp_sel), .instr(lnk_if.instr), .cp_accept(lnk_if.cp_accept),
        .mem_req(lnk_if.mem_req), .addr(lnk_if.addr), .user_translate_n(lnk_if.user_translate_n),
        .cache_en(lnk_if.cache_en), .mem_ack(lnk_if.mem_ack), .mem_abort(lnk_if.mem_abort),
        .last_word(lnk_if.last_word), .data_bus_enable_in(lnk_if.data_bus_enable_in),
        .dev_bus_oe(lnk_if.dev_bus_oe), .far_bus_oe(lnk_if.far_bus_oe));
    // ==========================================================
    // Clock and monitor
    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (lnk_if.mem_req === 1'b1) begin
            if (nreq == 0) first_addr = 32'(lnk_if.addr);
            last_addr = 32'(lnk_if.addr);
            nreq++;
        end
        if (lnk_if.user_translate_n === 1'b0) user_translate_n_low = 1'b1;
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            summarize();
        end
    endtask
    function automatic logic [31:0] mk(input logic [4:0] punwl, input logic [3:0] bsr,
        input logic [3:0] cp, input logic [7:0] off);
        return {7'h00, punwl, bsr, 4'h3, cp, off};
    endfunction
    task automatic run(input logic [31:0] ins, input logic [31:0] base, input logic [31:0] ctrl);
        int n;
        nreq = 0;
        user_translate_n_low = 1'b0;
        first_addr = 32'hffff_ffff;
        apb(1'b1, cpxfer_pkg::BASE_IN_OFS, base);
        apb(1'b1, cpxfer_pkg::INSTR_OFS, ins);
        apb(1'b1, cpxfer_pkg::CTRL_OFS, ctrl | 32'h0000_0001);
        n = 0;
        do begin
            apb(1'b0, cpxfer_pkg::STATUS_OFS, 32'h0000_0000);
            n++;
        end while (rd[cpxfer_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 40);
        if (n >= 40) begin
            miscompares++;
            summarize();
        end
    endtask
    // ==========================================================
    // Scenarios
    task automatic scen_regs();
        apb(1'b0, cpxfer_pkg::IRQ_MASK_OFS, 32'h0000_0000);
        check(rd, cpxfer_pkg::REG_RESET);
        apb(1'b1, cpxfer_pkg::IRQ_MASK_OFS, 32'h0000_000f);
        apb(1'b0, cpxfer_pkg::IRQ_MASK_OFS, 32'h0000_0000);
        check(rd, 32'h0000_000f);
        apb(1'b1, cpxfer_pkg::IRQ_MASK_OFS, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
    endtask
    task automatic scen_modes();
        logic [4:0] pw [7] = '{5'h1a, 5'h10, 5'h08, 5'h02, 5'h12, 5'h08, 5'h1a};
        logic [7:0] off [7] = '{8'hff, 8'h04, 8'h01, 8'h02, 8'h05, 8'h01, 8'h00};
        logic [31:0] bas [7] = '{32'h0000_1000, 32'h0000_1000, 32'h0000_2000, 32'h0000_2000,
            32'h0400_0010, 32'h03ff_fffc, 32'h0400_0000};
        logic [31:0] ea [7] = '{32'h0000_13fc, 32'h0000_0ff0, 32'h0000_2000, 32'h0000_2000,
            32'h03ff_fffc, 32'h03ff_fffc, 32'hffff_ffff};
        logic [31:0] eb [7] = '{32'h0000_13fc, 32'h0000_0000, 32'h0000_2004, 32'h0000_1ff8,
            32'h03ff_fffc, 32'h0400_0000, 32'h0000_0000};
        // Flags per case: write-back, translate low, address exception.
        logic [2:0] fl [7] = '{3'h4, 3'h0, 3'h4, 3'h6, 3'h4, 3'h4, 3'h1};
        for (int i = 0; i < 7; i++) begin
            run(mk(pw[i], 4'h2, 4'h1, off[i]), bas[i], 32'h0000_0004);
            check(first_addr, ea[i]);
            check(32'(nreq), 32'(!fl[i][0]));
            check(32'(user_translate_n_low), 32'(fl[i][1]));
            check(32'(irq), 32'h0000_0000);
            apb(1'b0, cpxfer_pkg::STATUS_OFS, 32'h0000_0000);
            check(32'(rd[cpxfer_pkg::STAT_WB_BIT]), 32'(fl[i][2]));
            apb(1'b0, cpxfer_pkg::BASE_OUT_OFS, 32'h0000_0000);
            if (fl[i][2]) check(rd, eb[i]);
            apb(1'b0, cpxfer_pkg::IRQ_STAT_OFS, 32'h0000_0000);
            check(rd, fl[i][0] ? 32'h0000_0002 : 32'h0000_0001);
        end
    endtask
    task automatic scen_long();
        bus_enable <= 1'b0;
        run(mk(5'h1c, 4'h4, 4'h1, 8'h00), 32'h03ff_fff8, 32'h0000_0000);
        bus_enable <= 1'b1;
        check(first_addr, 32'h03ff_fff8);
        check(32'(nreq), 32'(cpxfer_pkg::LONG_WORDS));
        check(last_addr, 32'h0000_0034);
        check(32'(words_done), 32'(cpxfer_pkg::LONG_WORDS));
        apb(1'b0, cpxfer_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        check(rd, 32'h0000_0001);
    endtask
    task automatic scen_pc_load();
        apb(1'b1, cpxfer_pkg::PC_IN_OFS, 32'hfc00_1001);
        run(mk(5'h19, cpxfer_pkg::PC_REG_NUM, 4'h1, 8'h01), 32'h0000_0000, 32'h0000_0002);
        check(first_addr, (32'hfc00_1001 & cpxfer_pkg::PC_MASK) + cpxfer_pkg::PC_AHEAD
            + 32'h0000_0004);
        check(32'(lnk_if.cache_en), 32'h0000_0001);
        apb(1'b0, cpxfer_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        check(rd, 32'h0000_0001);
    endtask
    task automatic scen_abort();
        abort_force <= 1'b1;
        run(mk(5'h08, 4'h5, 4'h1, 8'h02), 32'h0000_3000, 32'h0000_0000);
        abort_force <= 1'b0;
        apb(1'b0, cpxfer_pkg::BASE_OUT_OFS, 32'h0000_0000);
        check(rd, 32'h0000_3008);
        apb(1'b0, cpxfer_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        check(rd, 32'h0000_0004);
    endtask
    task automatic scen_nocp_irq();
        apb(1'b1, cpxfer_pkg::IRQ_MASK_OFS, 32'h0000_0008);
        run(mk(5'h18, 4'h2, 4'h2, 8'h00), 32'h0000_1000, 32'h0000_0000);
        check(32'(nreq), 32'h0000_0000);
        check(32'(irq), 32'h0000_0001);
        apb(1'b0, cpxfer_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        check(rd, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0000_0000);
        apb(1'b1, cpxfer_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        scen_regs();
        scen_modes();
        scen_long();
        scen_pc_load();
        scen_abort();
        scen_nocp_irq();
        summarize();
    end
endmodule
